// ### ifwa_fetch.sv
// Instruction fetch, word alignment and two-word assembly for the 8-bit core
`timescale 1ns/10ps
module ifwa_fetch (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Program memory read port, data one cycle after the strobe
    output logic pm_rd,
    output logic [ifwa_pkg::PC_W-1:0] pm_addr,
    input wire logic [7:0] pm_rdata,
    // Execute stage
    output logic exec_valid,
    output ifwa_pkg::ifwa_exec_s exec,
    input wire logic exec_ready,
    input wire logic skip_req,
    input wire logic cond_met,
    // Status
    output logic [ifwa_pkg::PC_W-1:0] pc
);
    import ifwa_pkg::*;

    // Fetch sequencer states
    typedef enum logic [3:0] {
        ST_LO = 4'b0001,
        ST_HI = 4'b0010,
        ST_DEC = 4'b0100,
        ST_HOLD = 4'b1000
    } ifwa_state_e;

    // Sequencer state
    ifwa_state_e state_q;
    ifwa_state_e state_d;

    // Word counter and address of a held first word
    logic [WA_W-1:0] wpc_q;
    logic [WA_W-1:0] wpc_d;
    logic [WA_W-1:0] ipc_q;
    logic [WA_W-1:0] ipc_d;

    // Low byte and held first word of a pair
    logic [7:0] lo_q;
    logic [15:0] first_q;
    logic [15:0] first_d;

    // Pending second word and pending skip
    logic second_q;
    logic second_d;
    logic skip_q;
    logic skip_d;

    // Instruction offered to the execute stage
    ifwa_exec_s exec_q;
    ifwa_exec_s exec_d;
    logic valid_q;
    logic valid_d;

    // Classifier results
    ifwa_dec_s dec;
    ifwa_dec_s dec1;

    // Word assembled from the two bytes
    wire [15:0] word = {pm_rdata, lo_q};
    wire [WA_W-1:0] wpc_inc = wpc_q + WORD_STEP;

    // Literal of a second word; an untagged word gives no literal to the execute stage but still fills the upper 12 bits of far_target
    wire [11:0] lit = word[11:0];
    wire lit_ok = (word[15:12] == SECOND_TAG);

    // Targets are word addresses, so bit 0 of the counter never moves
    wire [WA_W-1:0] far_target = {lit, first_q[7:0]};
    wire [WA_W-1:0] rel_target = wpc_inc + dec.offset;
    wire taken = (dec.kind == K_BRA) || ((dec.kind == K_BCOND) && cond_met);
    wire stall = valid_q && !exec_ready;

    // Classify the incoming word and the held first word
    ifwa_decode u_dec (
        .word(word),
        .dec(dec)
    );

    // Held first word, classified for the pair issue
    ifwa_decode u_dec1 (
        .word(first_q),
        .dec(dec1)
    );

    // Byte addresses out: even for the low byte, odd for the high byte
    assign pm_addr = {wpc_q, (state_q == ST_HI)};
    assign pm_rd = (state_q == ST_LO) || (state_q == ST_HI);

    // Status and execute outputs straight from registers
    assign pc = {wpc_q, 1'b0};
    assign exec_valid = valid_q;
    assign exec = exec_q;

    // Sequencer and decode
    always_comb begin
        // Everything holds by default, skip also latches skip_req; an accepted instruction drops
        state_d = state_q;
        wpc_d = wpc_q;
        ipc_d = ipc_q;
        first_d = first_q;
        second_d = second_q;
        skip_d = skip_q || skip_req;
        exec_d = exec_q;
        valid_d = valid_q && !exec_ready;
        case (state_q)
            ST_LO: begin
                // Even byte strobe out
                state_d = ST_HI;
            end

            ST_HI: begin
                // Odd byte strobe out, low byte lands
                state_d = ST_DEC;
            end

            ST_DEC: begin
                // Execute stage still busy: nothing is consumed
                if (stall) begin
                    state_d = ST_HOLD;
                end else if (second_q) begin
                    // Second word in sequence: its literal joins the first word
                    second_d = 1'b0;
                    valid_d = 1'b1;
                    exec_d.kind = dec1.kind;
                    exec_d.word1 = first_q;
                    exec_d.literal = lit_ok ? lit : 12'h000;
                    exec_d.pc = {ipc_q, 1'b0};
                    exec_d.next_pc = {wpc_inc, 1'b0};
                    // Jump and call load the word target, the rest step on
                    if (dec1.kind == K_JUMP || dec1.kind == K_CALL) begin
                        wpc_d = far_target;
                    end else begin
                        wpc_d = wpc_inc;
                    end
                    state_d = ST_LO;
                end else if (skip_q) begin
                    // Skipped word: counter moves on, nothing is issued
                    skip_d = skip_req;
                    wpc_d = wpc_inc;
                    state_d = ST_LO;
                end else if (dec.two_word) begin
                    // First of two words: hold it and fetch the literal word
                    first_d = word;
                    second_d = 1'b1;
                    ipc_d = wpc_q;
                    wpc_d = wpc_inc;
                    state_d = ST_LO;
                end else begin
                    // Single-word instruction or a lone second word
                    valid_d = 1'b1;
                    exec_d.kind = dec.kind;
                    exec_d.word1 = (dec.kind == K_NOP) ? NOP_WORD : word;
                    exec_d.literal = 12'h000;
                    exec_d.pc = {wpc_q, 1'b0};
                    exec_d.next_pc = {wpc_inc, 1'b0};
                    // Taken branch moves by the word offset
                    wpc_d = taken ? rel_target : wpc_inc;
                    state_d = ST_LO;
                end
            end

            ST_HOLD: begin
                // Execute stage busy: refetch the same word once it frees
                if (!stall) begin
                    state_d = ST_LO;
                end
            end

            default: begin
                // Illegal code: restart the fetch of the current word
                state_d = ST_LO;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ST_LO;
            wpc_q <= RESET_WADDR;
            ipc_q <= RESET_WADDR;
            first_q <= NOP_WORD;
            second_q <= 1'b0;
            skip_q <= 1'b0;
            exec_q <= '0;
            valid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wpc_q <= wpc_d;
            ipc_q <= ipc_d;
            first_q <= first_d;
            second_q <= second_d;
            skip_q <= skip_d;
            exec_q <= exec_d;
            valid_q <= valid_d;
        end
    end

    // Low byte capture, one cycle after the even read
    always_ff @(posedge clk) begin
        if (srst) begin
            lo_q <= 8'h00;
        end else if (state_q == ST_HI) begin
            lo_q <= pm_rdata;
        end
    end

endmodule // ifwa_fetch

// ### ifwa_pkg.sv
// Package for the instruction fetch and word-align block: constants, kinds and carriers
package ifwa_pkg;

    // Program memory geometry
    localparam int PC_W = 21;                 // Byte program counter, bits 20..0
    localparam int WA_W = 20;                 // Word address, program counter bits 20..1
    localparam int WORD_BYTES = 2;            // Bytes per instruction word
    localparam int MAX_INSTR_BYTES = 4;       // Bytes of a two-word instruction
    localparam logic [WA_W-1:0] RESET_WADDR = 20'h00000;
    localparam logic [WA_W-1:0] WORD_STEP = 20'h00001;  // One word, two bytes

    // Opcode fields
    localparam logic [3:0] SECOND_TAG = 4'hf;           // Top nibble of a second word
    localparam logic [7:0] OP_JUMP = 8'hef;             // 1110 1111 kkkk kkkk
    localparam logic [6:0] OP_CALL = 7'h76;             // 1110 110s kkkk kkkk
    localparam logic [3:0] OP_MOVE = 4'hc;              // 1100 ffff ffff ffff
    localparam logic [9:0] OP_LDPTR = 10'h3b8;          // 1110 1110 00ff kkkk
    localparam logic [4:0] OP_BRA = 5'h1a;              // 1101 0nnn nnnn nnnn
    localparam logic [4:0] OP_BCOND = 5'h1c;            // 1110 0ccc nnnn nnnn
    localparam logic [15:0] NOP_WORD = 16'h0000;

    // Instruction kinds seen by the core
    typedef enum logic [3:0] {
        K_PLAIN = 4'h0,
        K_JUMP = 4'h1,
        K_CALL = 4'h2,
        K_MOVE = 4'h3,
        K_LDPTR = 4'h4,
        K_BRA = 4'h5,
        K_BCOND = 4'h6,
        K_NOP = 4'h7
    } ifwa_kind_e;

    // Decoder result for one word
    typedef struct packed {
        ifwa_kind_e kind;
        logic two_word;
        logic [WA_W-1:0] offset;   // Signed word offset, sign extended
    } ifwa_dec_s;

    // Instruction handed to the execute stage
    typedef struct packed {
        ifwa_kind_e kind;
        logic [15:0] word1;
        logic [11:0] literal;      // Literal of the second word, zero otherwise
        logic [PC_W-1:0] pc;       // Byte address of the first word
        logic [PC_W-1:0] next_pc;  // Byte address after the whole instruction
    } ifwa_exec_s;

endpackage

// ### ifwa_decode.sv
// Single-word opcode classifier for the fetch unit
`timescale 1ns/10ps
module ifwa_decode (
    // Word under decode
    input wire logic [15:0] word,
    // Classification
    output ifwa_pkg::ifwa_dec_s dec
);
    import ifwa_pkg::*;

    // Opcode matches
    wire is_second = (word[15:12] == SECOND_TAG);
    wire is_jump = (word[15:8] == OP_JUMP);
    wire is_call = (word[15:9] == OP_CALL);
    wire is_move = (word[15:12] == OP_MOVE);
    wire is_ldptr = (word[15:6] == OP_LDPTR);
    wire is_bra = (word[15:11] == OP_BRA);
    wire is_bcond = (word[15:11] == OP_BCOND);

    // Sign extended word offsets, counted in single-word instructions
    wire [WA_W-1:0] off11 = {{(WA_W-11){word[10]}}, word[10:0]};
    wire [WA_W-1:0] off8 = {{(WA_W-8){word[7]}}, word[7:0]};

    // Priority: a lone 1111 word is a no-operation
    assign dec.kind = is_second ? K_NOP :
                      is_jump ? K_JUMP :
                      is_call ? K_CALL :
                      is_move ? K_MOVE :
                      is_ldptr ? K_LDPTR :
                      is_bra ? K_BRA :
                      is_bcond ? K_BCOND : K_PLAIN;
    assign dec.two_word = !is_second && (is_jump || is_call || is_move || is_ldptr);
    assign dec.offset = is_bra ? off11 : off8;

endmodule // ifwa_decode

// ### ifwa_props.sv
// Port checker for the fetch and word-align block
`timescale 1ns/10ps
module ifwa_props (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Program memory port
    input wire logic pm_rd,
    input wire logic [ifwa_pkg::PC_W-1:0] pm_addr,
    // Execute stage and status
    input wire logic exec_valid,
    input wire ifwa_pkg::ifwa_exec_s exec,
    input wire logic exec_ready,
    input wire logic [ifwa_pkg::PC_W-1:0] pc
);
    import ifwa_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Even byte read and a pending instruction
    sequence s_lo;
        pm_rd && !pm_addr[0];
    endsequence
    sequence s_hold;
        exec_valid && !exec_ready;
    endsequence
    // First cycle of a newly issued instruction
    sequence s_issue;
        exec_valid && (!$past(exec_valid) || $past(exec_ready));
    endsequence
    // Byte pairing, alignment and targets
    AST_BYTE_PAIR: assert property (s_lo |=> pm_rd && pm_addr == $past(pm_addr) + 21'h1)
        else $error("odd byte read does not follow even byte");
    AST_EXEC_HOLD: assert property (s_hold |=> exec_valid && $stable(exec))
        else $error("pending instruction changed");
    AST_PC_EVEN: assert property (!pc[0] && (!pm_rd || pm_addr[20:1] == pc[20:1]))
        else $error("pc odd or fetch address off the counter");
    AST_EXEC_EVEN: assert property (exec_valid |-> !exec.pc[0] && !exec.next_pc[0])
        else $error("instruction address odd");
    AST_PLAIN_STEP: assert property (exec_valid && exec.kind == K_PLAIN |->
        exec.next_pc == exec.pc + 21'h2) else $error("plain step wrong");
    AST_ABS_TARGET: assert property (s_issue ##0 exec.kind inside {K_JUMP, K_CALL} |->
        pc == {exec.literal, exec.word1[7:0], 1'b0} && exec.next_pc == exec.pc + 21'h4)
        else $error("abs target wrong");
    AST_BRA_WORDS: assert property (s_issue ##0 exec.kind == K_BRA |->
        pc == exec.pc + 21'h2 + {{9{exec.word1[10]}}, exec.word1[10:0], 1'b0}
        && exec.next_pc == exec.pc + 21'h2) else $error("branch target wrong");
    AST_TWO_WORD: assert property (exec_valid && exec.kind inside {K_MOVE, K_LDPTR} |->
        exec.next_pc == exec.pc + 21'h4) else $error("two-word length wrong");
    AST_NOP_ALONE: assert property (exec_valid && exec.kind == K_NOP |->
        exec.next_pc == exec.pc + 21'h2 && exec.word1 == 16'h0000) else $error("nop wrong");
endmodule // ifwa_props

bind ifwa_fetch ifwa_props u_props (.clk(clk), .srst(srst), .pm_rd(pm_rd), .pm_addr(pm_addr),
    .exec_valid(exec_valid), .exec(exec), .exec_ready(exec_ready), .pc(pc));

// ### ifwa_pmem.sv
// Program memory model: byte array, data one cycle after the strobe
`timescale 1ns/10ps
module ifwa_pmem (
    // Clock
    input wire logic clk,
    // Read port
    input wire logic rd,
    input wire logic [20:0] addr,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:1023];
    // Byte read; idle cycles show inverted data
    initial rdata = 8'h00;
    always @(posedge clk) rdata <= rd ? mem[addr[9:0]] : ~rdata;
endmodule // ifwa_pmem

// ### ifwa_tb.sv
// Self-checking bench for the fetch and word-align block
`timescale 1ns/10ps
module testbench;
    import ifwa_pkg::*;
    logic clk, srst, exec_ready, skip_req, cond_met, pm_rd, exec_valid;
    logic [PC_W-1:0] pm_addr, pc;
    logic [7:0] pm_rdata;
    ifwa_exec_s exec;
    int failures = 0;
    int check_count = 0;
    logic [31:0] seed = 32'd10654;
    // Design and memory
    ifwa_fetch dut (.clk(clk), .srst(srst), .pm_rd(pm_rd), .pm_addr(pm_addr),
        .pm_rdata(pm_rdata), .exec_valid(exec_valid), .exec(exec), .exec_ready(exec_ready),
        .skip_req(skip_req), .cond_met(cond_met), .pc(pc));
    ifwa_pmem pm (.clk(clk), .rd(pm_rd), .addr(pm_addr), .rdata(pm_rdata));
    // Clock
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Branch target from a word offset
    function logic [20:0] rel(input logic [20:0] p, input logic [20:0] w);
        return p + 21'h2 + (w << 1);
    endfunction
    task put(input logic [8:0] wa, input logic [15:0] w);
        pm.mem[{wa, 1'b0}] = w[7:0];
        pm.mem[{wa, 1'b1}] = w[15:8];
    endtask
    task cmp(input string n, input logic [20:0] e, input logic [20:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Wait for an instruction, accept it after a random stall, compare
    // t is the byte address the counter must hold while the instruction waits
    task chk(input ifwa_kind_e k, input logic [20:0] p, input logic [20:0] np,
        input logic [20:0] t, input logic [11:0] l);
        ifwa_exec_s e;
        int n;
        @(negedge clk);
        for (n = 0; n < 60 && !(exec_valid === 1'b1 && rnd() % 2); n++) @(negedge clk);
        cmp("exec_valid", 21'h1, 21'(exec_valid));
        e = exec;
        cmp("pc_out", t, pc);
        exec_ready = 1;
        @(negedge clk);
        exec_ready = 0;
        cmp("kind", 21'(k), 21'(e.kind));
        cmp("pc", p, e.pc);
        cmp("next_pc", np, e.next_pc);
        if (k inside {K_JUMP, K_CALL, K_MOVE, K_LDPTR}) cmp("literal", 21'(l), 21'(e.literal));
    endtask
    task print_verdict;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Watchdog
    initial begin
        #100000;
        failures++;
        print_verdict;
    end
    // Main sequence
    initial begin
        logic [31:0] w;
        logic [20:0] a;
        srst = 1;
        exec_ready = 0;
        skip_req = 0;
        cond_met = 1;
        for (int i = 0; i < 512; i++) begin
            w = rnd();
            put(9'(i), {4'h2, w[11:0]});
        end
        w = rnd();
        put(9'h000, {10'h3b8, 6'h03});
        put(9'h001, 16'hf0a5);
        put(9'h003, {7'h76, 1'b0, 8'h80});
        put(9'h004, 16'hf000);
        put(9'h080, 16'hef40);
        put(9'h081, 16'hf001);
        put(9'h140, {5'h1a, 11'h7fc});
        put(9'h13d, {5'h1c, 3'h0, 8'h10});
        put(9'h14e, {4'hc, w[23:12]});
        put(9'h14f, {4'hf, w[11:0]});
        put(9'h155, {5'h1c, 3'h0, 8'h40});
        put(9'h15e, {10'h3b8, 6'h05});
        put(9'h15f, 16'hf123);
        repeat (4) @(negedge clk);
        srst = 0;
        skip_req = 1;
        @(negedge clk);
        skip_req = 0;
        chk(K_NOP, 21'h2, 21'h4, 21'h4, 12'h0);
        chk(K_PLAIN, 21'h4, 21'h6, 21'h6, 12'h0);
        chk(K_CALL, 21'h6, 21'ha, 21'h100, 12'h000);
        chk(K_JUMP, 21'h100, 21'h104, 21'h280, 12'h001);
        chk(K_BRA, 21'h280, 21'h282, rel(21'h280, -21'd4), 12'h0);
        chk(K_BCOND, 21'h27a, 21'h27c, rel(21'h27a, 21'h10), 12'h0);
        chk(K_MOVE, 21'h29c, 21'h2a0, 21'h2a0, w[11:0]);
        $display("test skip_and_branches done");
        // Conditional branch at byte 2aa is not taken in this run
        cond_met = 0;
        for (int i = 0; i < 14; i++) begin
            a = 21'h2a0 + 21'(2 * i);
            chk((i == 5) ? K_BCOND : K_PLAIN, a, a + 21'h2, a + 21'h2, 12'h0);
        end
        chk(K_LDPTR, 21'h2bc, 21'h2c0, 21'h2c0, 12'h123);
        $display("test sequential_run done");
        print_verdict;
    end
endmodule // testbench
